// file: rtl/acr_regs.sv
// APB register bank for two-channel calibration, input selection, clock divider and isolated supply control.
//
// Contract
// R1 - Each channel's gain trim is a 24-bit unsigned factor, high word bits 23:8, low register bits 15:8 bits 7:0.
// R2 - Gain trim high words reset to 8000h and low words to 0000h, giving unity gain.
// R3 - Bits 7:0 of every offset and gain low register always read zero and ignore writes.
// R4 - Each channel's offset trim is a 24-bit two's-complement value split the same way, resetting to zero.
// R5 - Bits 15:6 of each channel configuration register hold a 10-bit signed phase delay that resets to zero.
// R6 - Bits 5:2 of each channel configuration register are read-only zero.
// R7 - Bits 1:0 of each channel configuration register select normal, shorted, DC or AC diagnostic input.
// R8 - Bits 11:8 of the supply control register select the modulator clock frequency band.
// R9 - Bit 0 of the supply control register switches the isolated converter on, and resets clear.
// R10 - The host writes zeros to bits 15:12 and 7:1 of the supply control register.
// R11 - The host picks a frequency band that holds the real modulator clock frequency.
// R12 - The modulator clock is the external clock divided by 2, 4, 8 or 12 per a 2-bit code.
// R13 - The stored offset trim is subtracted from each channel's conversion result.
// R14 - The offset-corrected result is multiplied by the stored gain trim.
// R15 - A corrected result beyond the signed 24-bit range saturates to full scale instead of wrapping.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module acr_regs
    import acr_pkg::*;
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [acr_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [acr_pkg::DATA_W-1:0]    pwdata,
    input  wire logic [acr_pkg::STRB_W-1:0]    pstrb,
    output logic [acr_pkg::DATA_W-1:0]         prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          external_clock_input,
    output logic                               mod_clk_tick,
    output logic                               mod_clk_level,
    input  wire logic                          sample_valid,
    input  wire logic [acr_pkg::SAMPLE_W-1:0]  ch0_raw_sample,
    input  wire logic [acr_pkg::SAMPLE_W-1:0]  ch1_raw_sample,
    output logic                               result_valid,
    output logic [acr_pkg::SAMPLE_W-1:0]       ch0_result,
    output logic [acr_pkg::SAMPLE_W-1:0]       ch1_result,
    output logic                               ch0_result_clipped,
    output logic                               ch1_result_clipped,
    output logic [acr_pkg::PHASE_W-1:0]        ch0_phase_delay,
    output logic [acr_pkg::PHASE_W-1:0]        ch1_phase_delay,
    output logic [acr_pkg::SEL_W-1:0]          ch0_input_select,
    output logic [acr_pkg::SEL_W-1:0]          ch1_input_select,
    output logic                               supply_converter_on,
    output logic [acr_pkg::FREQ_W-1:0]         supply_freq_band
);
    import acr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic [IDX_W-1:0] ch_base(input int unsigned ch);
        ch_base = CH0_CONFIG_IDX + IDX_W'(ch) * CH_STRIDE;
    endfunction : ch_base

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx       = reg_index(addr);
        is_mapped = (addr[1:0] == 2'h0) &&
                    (((idx >= CH0_CONFIG_IDX) && (idx <= CH1_GAIN_TRIM_LOW_IDX)) ||
                     (idx == CLOCK_DIVIDER_IDX) || (idx == ISOLATED_SUPPLY_CTRL_IDX));
    endfunction : is_mapped

    // Byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are dropped.
    function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0]  old_val,
                                                     input logic [DATA_W-1:0] wdata,
                                                     input logic [STRB_W-1:0] strb);
        lane_merge       = old_val;
        if (strb[0]) begin
            lane_merge[7:0]  = wdata[7:0];
        end
        if (strb[1]) begin
            lane_merge[15:8] = wdata[15:8];
        end
    endfunction : lane_merge

    function automatic logic [CNT_W-1:0] div_ratio(input logic [DIV_W-1:0] code);
        unique case (code)
            2'h0: div_ratio = DIV_RATIO_0;
            2'h1: div_ratio = DIV_RATIO_1;
            2'h2: div_ratio = DIV_RATIO_2;
            2'h3: div_ratio = DIV_RATIO_3;
        endcase
    endfunction : div_ratio

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [REG_W-1:0]       config_r     [NUM_CH];
    logic [REG_W-1:0]       ofs_high_r   [NUM_CH];
    logic [LOW_BYTE_W-1:0]  ofs_low_r    [NUM_CH];
    logic [REG_W-1:0]       gain_high_r  [NUM_CH];
    logic [LOW_BYTE_W-1:0]  gain_low_r   [NUM_CH];
    logic [SAMPLE_W-1:0]    raw_in       [NUM_CH];
    logic [SAMPLE_W-1:0]    res_out      [NUM_CH];
    logic                   clip_out     [NUM_CH];
    logic                   valid_out    [NUM_CH];
    logic [REG_W-1:0]       supply_r;
    logic [DIV_W-1:0]       clkdiv_r;
    logic [IDX_W-1:0]       acc_idx;
    logic                   wr_en;
    logic                   setup;
    logic [REG_W-1:0]       rd_nxt;
    logic [DATA_W-1:0]      prdata_r;
    logic                   pslverr_r;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // APB slave: read data and error are captured in the setup cycle so the access phase needs no wait.
    assign acc_idx = reg_index(paddr);
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && is_mapped(paddr);
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r && psel && penable;

    always_comb begin
        rd_nxt = '0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (acc_idx == ch_base(ch)) begin
                rd_nxt = config_r[ch] & CONFIG_RW_MASK; // R6
            end
            if (acc_idx == ch_base(ch) + OFS_HIGH_REL) begin
                rd_nxt = ofs_high_r[ch];
            end
            if (acc_idx == ch_base(ch) + OFS_LOW_REL) begin
                rd_nxt = {ofs_low_r[ch], 8'h00}; // R3
            end
            if (acc_idx == ch_base(ch) + GAIN_HIGH_REL) begin
                rd_nxt = gain_high_r[ch];
            end
            if (acc_idx == ch_base(ch) + GAIN_LOW_REL) begin
                rd_nxt = {gain_low_r[ch], 8'h00}; // R3
            end
        end
        if (acc_idx == CLOCK_DIVIDER_IDX) begin
            rd_nxt = {{(REG_W-DIV_W){1'b0}}, clkdiv_r};
        end
        if (acc_idx == ISOLATED_SUPPLY_CTRL_IDX) begin
            rd_nxt = supply_r;
        end
        if (!is_mapped(paddr)) begin
            rd_nxt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup) begin
            prdata_r <= (!pwrite) ? {{(DATA_W-REG_W){1'b0}}, rd_nxt} : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !is_mapped(paddr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Per-channel registers.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        localparam logic [IDX_W-1:0] BASE = CH0_CONFIG_IDX + IDX_W'(g) * CH_STRIDE;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                config_r[g] <= CONFIG_RST; // R5
            end else if (wr_en && acc_idx == BASE) begin
                config_r[g] <= lane_merge(config_r[g], pwdata, pstrb) & CONFIG_RW_MASK; // R5 R6 R7
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ofs_high_r[g] <= OFS_HIGH_RST; // R4
            end else if (wr_en && acc_idx == BASE + OFS_HIGH_REL) begin
                ofs_high_r[g] <= lane_merge(ofs_high_r[g], pwdata, pstrb); // R4
            end
        end

        // Only lane 1 reaches the low byte; lane 0 lands on read-only zeros.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ofs_low_r[g] <= OFS_LOW_RST; // R4
            end else if (wr_en && acc_idx == BASE + OFS_LOW_REL && pstrb[1]) begin
                ofs_low_r[g] <= pwdata[LOW_BYTE_LSB +: LOW_BYTE_W]; // R4 R3
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gain_high_r[g] <= GAIN_HIGH_RST; // R2
            end else if (wr_en && acc_idx == BASE + GAIN_HIGH_REL) begin
                gain_high_r[g] <= lane_merge(gain_high_r[g], pwdata, pstrb); // R1
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gain_low_r[g] <= GAIN_LOW_RST; // R2
            end else if (wr_en && acc_idx == BASE + GAIN_LOW_REL && pstrb[1]) begin
                gain_low_r[g] <= pwdata[LOW_BYTE_LSB +: LOW_BYTE_W]; // R1 R3
            end
        end

        acr_correct u_correct (
            .pclk           (pclk),
            .presetn        (presetn),
            .sample_valid   (sample_valid),
            .raw_sample     (raw_in[g]),
            .offset_trim    ({ofs_high_r[g], ofs_low_r[g]}), // R4 R13
            .gain_trim      ({gain_high_r[g], gain_low_r[g]}), // R1 R14
            .result_valid   (valid_out[g]),
            .result         (res_out[g]),
            .result_clipped (clip_out[g])
        );
    end

    assign raw_in[0]          = ch0_raw_sample;
    assign raw_in[1]          = ch1_raw_sample;
    assign result_valid       = valid_out[0] && valid_out[1];
    assign ch0_result         = res_out[0];
    assign ch1_result         = res_out[1];
    assign ch0_result_clipped = clip_out[0];
    assign ch1_result_clipped = clip_out[1];
    assign ch0_phase_delay    = config_r[0][PHASE_LSB +: PHASE_W]; // R5
    assign ch1_phase_delay    = config_r[1][PHASE_LSB +: PHASE_W]; // R5
    assign ch0_input_select   = config_r[0][SEL_LSB +: SEL_W]; // R7
    assign ch1_input_select   = config_r[1][SEL_LSB +: SEL_W]; // R7

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Supply control keeps the reserved bits as written; software is expected to leave them zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_r <= SUPPLY_RST; // R9
        end else if (wr_en && acc_idx == ISOLATED_SUPPLY_CTRL_IDX) begin
            supply_r <= lane_merge(supply_r, pwdata, pstrb); // R8 R9
        end
    end

    assign supply_converter_on = supply_r[CONV_ON_BIT]; // R9
    assign supply_freq_band    = supply_r[FREQ_LSB +: FREQ_W]; // R8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkdiv_r <= CLKDIV_RST;
        end else if (wr_en && acc_idx == CLOCK_DIVIDER_IDX && pstrb[0]) begin
            clkdiv_r <= pwdata[DIV_W-1:0]; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Modulator clock divider. The external clock is sampled by pclk, so it must stay below half of pclk.
    logic               ext_meta_r;
    logic               ext_sync_r;
    logic               ext_prev_r;
    logic               ext_rise;
    logic [CNT_W-1:0]   edge_cnt_r;
    logic [CNT_W-1:0]   ratio;
    logic               tick_r;
    logic               level_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_meta_r <= external_clock_input;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    assign ext_rise = ext_sync_r && !ext_prev_r;
    assign ratio    = div_ratio(clkdiv_r);

    // A smaller ratio written mid-period wraps on the next external rising edge rather than running the counter out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_r <= '0;
        end else if (ext_rise) begin
            edge_cnt_r <= (edge_cnt_r >= ratio - 4'h1) ? '0 : edge_cnt_r + 4'h1; // R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= ext_rise && (edge_cnt_r >= ratio - 4'h1); // R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else begin
            level_r <= (edge_cnt_r < (ratio >> 1)); // R12
        end
    end

    assign mod_clk_tick  = tick_r;
    assign mod_clk_level = level_r;

endmodule : acr_regs
`default_nettype wire

// file: include/acr_pkg.sv
// Constants, register map and field layout of the channel calibration register bank.
package acr_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 16;
    localparam int unsigned IDX_W    = 6;
    localparam int unsigned SAMPLE_W = 24;
    localparam int unsigned NUM_CH   = 2;
    localparam int unsigned STRB_W   = 4;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] CH0_CONFIG_IDX           = 6'h09;
    localparam logic [IDX_W-1:0] CH0_OFFSET_TRIM_HIGH_IDX = 6'h0a;
    localparam logic [IDX_W-1:0] CH0_OFFSET_TRIM_LOW_IDX  = 6'h0b;
    localparam logic [IDX_W-1:0] CH0_GAIN_TRIM_HIGH_IDX   = 6'h0c;
    localparam logic [IDX_W-1:0] CH0_GAIN_TRIM_LOW_IDX    = 6'h0d;
    localparam logic [IDX_W-1:0] CH1_CONFIG_IDX           = 6'h0e;
    localparam logic [IDX_W-1:0] CH1_OFFSET_TRIM_HIGH_IDX = 6'h0f;
    localparam logic [IDX_W-1:0] CH1_OFFSET_TRIM_LOW_IDX  = 6'h10;
    localparam logic [IDX_W-1:0] CH1_GAIN_TRIM_HIGH_IDX   = 6'h11;
    localparam logic [IDX_W-1:0] CH1_GAIN_TRIM_LOW_IDX    = 6'h12;
    localparam logic [IDX_W-1:0] CLOCK_DIVIDER_IDX        = 6'h20;
    localparam logic [IDX_W-1:0] ISOLATED_SUPPLY_CTRL_IDX = 6'h31;
    localparam logic [IDX_W-1:0] CH_STRIDE                = 6'h05;
    localparam logic [IDX_W-1:0] OFS_HIGH_REL             = 6'h01;
    localparam logic [IDX_W-1:0] OFS_LOW_REL              = 6'h02;
    localparam logic [IDX_W-1:0] GAIN_HIGH_REL            = 6'h03;
    localparam logic [IDX_W-1:0] GAIN_LOW_REL             = 6'h04;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned PHASE_LSB     = 6;
    localparam int unsigned PHASE_W       = 10;
    localparam int unsigned SEL_LSB       = 0;
    localparam int unsigned SEL_W         = 2;
    localparam int unsigned LOW_BYTE_LSB  = 8;
    localparam int unsigned LOW_BYTE_W    = 8;
    localparam int unsigned FREQ_LSB      = 8;
    localparam int unsigned FREQ_W        = 4;
    localparam int unsigned CONV_ON_BIT   = 0;
    localparam int unsigned DIV_W         = 2;
    localparam int unsigned CNT_W         = 4;
    localparam int unsigned GAIN_FRAC     = 23;

    localparam logic [REG_W-1:0]      CONFIG_RW_MASK = 16'hffc3;
    localparam logic [REG_W-1:0]      CONFIG_RST     = 16'h0000;
    localparam logic [REG_W-1:0]      OFS_HIGH_RST   = 16'h0000;
    localparam logic [LOW_BYTE_W-1:0] OFS_LOW_RST    = 8'h00;
    localparam logic [REG_W-1:0]      GAIN_HIGH_RST  = 16'h8000;
    localparam logic [LOW_BYTE_W-1:0] GAIN_LOW_RST   = 8'h00;
    localparam logic [REG_W-1:0]      SUPPLY_RST     = 16'h0000;
    localparam logic [DIV_W-1:0]      CLKDIV_RST     = 2'h0;

    localparam logic [CNT_W-1:0] DIV_RATIO_0 = 4'h2;
    localparam logic [CNT_W-1:0] DIV_RATIO_1 = 4'h4;
    localparam logic [CNT_W-1:0] DIV_RATIO_2 = 4'h8;
    localparam logic [CNT_W-1:0] DIV_RATIO_3 = 4'hc;

    localparam logic [SAMPLE_W-1:0] SAT_MAX = 24'h7fffff;
    localparam logic [SAMPLE_W-1:0] SAT_MIN = 24'h800000;

    typedef enum logic [SEL_W-1:0] {
        ACR_SEL_NORMAL  = 2'h0,
        ACR_SEL_SHORTED = 2'h1,
        ACR_SEL_DC_DIAG = 2'h2,
        ACR_SEL_AC_DIAG = 2'h3
    } acr_input_sel_e;

endpackage : acr_pkg

// file: rtl/acr_correct.sv
// Offset subtraction, gain scaling and saturation of one channel's conversion result.
`timescale 1ns/1ps
`default_nettype none
module acr_correct
    import acr_pkg::*;
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          sample_valid,
    input  wire logic [acr_pkg::SAMPLE_W-1:0]  raw_sample,
    input  wire logic [acr_pkg::SAMPLE_W-1:0]  offset_trim,
    input  wire logic [acr_pkg::SAMPLE_W-1:0]  gain_trim,
    output logic                               result_valid,
    output logic [acr_pkg::SAMPLE_W-1:0]       result,
    output logic                               result_clipped
);
    import acr_pkg::*;

    logic signed [SAMPLE_W:0]       diff;
    logic signed [SAMPLE_W:0]       gain_s;
    logic signed [2*SAMPLE_W+1:0]   product;
    logic signed [SAMPLE_W+2:0]     scaled;
    logic [SAMPLE_W-1:0]            sat_nxt;
    logic                           clip_nxt;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // One extra bit on the difference keeps full-scale minus full-scale from wrapping.
    always_comb begin
        diff    = $signed({raw_sample[SAMPLE_W-1], raw_sample}) - $signed({offset_trim[SAMPLE_W-1], offset_trim}); // R13
        gain_s  = $signed({1'b0, gain_trim}); // R1
        product = diff * gain_s; // R14
        scaled  = product[GAIN_FRAC+SAMPLE_W+2:GAIN_FRAC];
        if (scaled > $signed({3'h0, SAT_MAX})) begin
            sat_nxt  = SAT_MAX; // R15
            clip_nxt = 1'b1;
        end else if (scaled < $signed({3'h7, SAT_MIN})) begin
            sat_nxt  = SAT_MIN; // R15
            clip_nxt = 1'b1;
        end else begin
            sat_nxt  = scaled[SAMPLE_W-1:0];
            clip_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result         <= '0;
            result_clipped <= 1'b0;
        end else if (sample_valid) begin
            result         <= sat_nxt;
            result_clipped <= clip_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= sample_valid;
        end
    end

endmodule : acr_correct
`default_nettype wire

// file: tb/acr_regs_properties.sv
// Port-level properties of the calibration register bank.
`timescale 1ns/1ps
`default_nettype none
module acr_regs_properties (
    input wire logic        pclk, presetn, psel, penable, pwrite, sample_valid, result_valid,
    input wire logic        ch1_result_clipped, supply_converter_on,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  pstrb, supply_freq_band,
    input wire logic [23:0] ch1_result,
    input wire logic [9:0]  ch1_phase_delay,
    input wire logic [1:0]  ch0_input_select
);
    logic w, r;
    assign w = psel & penable & pwrite & (&pstrb[1:0]);
    assign r = psel & penable & !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    property p_on; w && paddr == 8'hc4 |=> supply_converter_on == $past(pwdata[0]); endproperty
    a_on: assert property (p_on) else $error("enable bit wrong");
    property p_band; w && paddr == 8'hc4 |=> supply_freq_band == $past(pwdata[11:8]); endproperty
    a_band: assert property (p_band) else $error("band wrong");
    property p_phase; w && paddr == 8'h38 |=> ch1_phase_delay == $past(pwdata[15:6]); endproperty
    a_phase: assert property (p_phase) else $error("phase wrong");
    property p_sel; w && paddr == 8'h24 |=> ch0_input_select == $past(pwdata[1:0]); endproperty
    a_sel: assert property (p_sel) else $error("select wrong");
    property p_low; r && paddr inside {8'h2c, 8'h34, 8'h40, 8'h48} |-> prdata[7:0] == 8'h00; endproperty
    a_low: assert property (p_low) else $error("low byte not zero");
    property p_rsv; r && paddr inside {8'h24, 8'h38} |-> prdata[5:2] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("config gap not zero");
    property p_lat; sample_valid |=> result_valid; endproperty
    a_lat: assert property (p_lat) else $error("no result");
    property p_sat; ch1_result_clipped |-> ch1_result inside {24'h7fffff, 24'h800000}; endproperty
    a_sat: assert property (p_sat) else $error("clip not full scale");
    c_wr: cover property (w && paddr == 8'hc4);
    c_clip: cover property (ch1_result_clipped);
    c_res: cover property (result_valid);
endmodule : acr_regs_properties
bind acr_regs acr_regs_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .sample_valid,
    .result_valid, .ch1_result_clipped, .supply_converter_on, .paddr, .pwdata, .prdata, .pstrb,
    .supply_freq_band, .ch1_result, .ch1_phase_delay, .ch0_input_select);
`default_nettype wire

// file: tb/acr_host.sv
// Behavioural APB host that programs the calibration register bank.
`timescale 1ns/1ps
`default_nettype none
module acr_host (
    input  wire logic        pclk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel, penable, pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end
    // Bus is inverted on release so a stale value never passes for a live one.
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic wr,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= (a == 8'hc4) ? (d & 32'h0f01) : d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : acr_host
`default_nettype wire

// file: tb/test_acr_regs.sv
// Self-checking testbench of the calibration register bank.
`timescale 1ns/1ps
`default_nettype none
module test_acr_regs;
    import acr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic external_clock_input = 1'b0;
    logic sample_valid = 1'b0;
    logic [23:0] ch0_raw_sample = 24'h0, ch1_raw_sample = 24'h0, ch0_result, ch1_result;
    logic psel, penable, pwrite, pready, pslverr, mod_clk_tick, mod_clk_level, result_valid;
    logic ch0_result_clipped, ch1_result_clipped, supply_converter_on;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, supply_freq_band;
    logic [9:0] ch0_phase_delay, ch1_phase_delay;
    logic [1:0] ch0_input_select, ch1_input_select;
    int fails = 0;
    int tests_run = 0;
    int rat [4] = '{2, 4, 8, 12};
    logic [15:0] msk [5] = '{16'hffc3, 16'hffff, 16'hff00, 16'hffff, 16'hff00};
    always #50 pclk = ~pclk;
    always #500 external_clock_input = ~external_clock_input;
    acr_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
    acr_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .external_clock_input, .mod_clk_tick, .mod_clk_level, .sample_valid, .ch0_raw_sample,
        .ch1_raw_sample, .result_valid, .ch0_result, .ch1_result, .ch0_result_clipped, .ch1_result_clipped,
        .ch0_phase_delay, .ch1_phase_delay, .ch0_input_select, .ch1_input_select, .supply_converter_on,
        .supply_freq_band);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        tests_run++;
        if (act !== exp) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        logic [31:0] q;
        logic e;
        host.xfer({i, 2'b00}, {16'h0, d}, 1'b1, q, e);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        host.xfer(a, 32'h0, 1'b0, q, e);
        chk(q, {16'h0, x});
        chk(32'(e), 32'(xe));
    endtask : rd
    task automatic smp(input logic [23:0] a0, a1, x0, x1, input logic [1:0] k);
        @(posedge pclk);
        sample_valid <= 1'b1;
        ch0_raw_sample <= a0;
        ch1_raw_sample <= a1;
        @(posedge pclk);
        sample_valid <= 1'b0;
        #1;
        chk(32'(result_valid), 32'h1);
        chk(32'(ch0_result), 32'(x0));
        chk(32'(ch1_result), 32'(x1));
        chk(32'({ch1_result_clipped, ch0_result_clipped}), 32'(k));
    endtask : smp
    task automatic test_done();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        fails++;
        test_done();
    end
    initial begin
        int n, h;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) rd(8'h24 + 8'(4 * i), (i % 5 == 3) ? 16'h8000 : 16'h0, 1'b0);
        rd(8'hc4, 16'h0, 1'b0);
        for (int i = 0; i < 10; i++) wr(6'h09 + 6'(i), 16'hffff);
        wr(ISOLATED_SUPPLY_CTRL_IDX, 16'hffff);
        for (int i = 0; i < 10; i++) rd(8'h24 + 8'(4 * i), msk[i % 5], 1'b0);
        rd(8'hc4, 16'h0f01, 1'b0);
        chk(32'({ch0_phase_delay, ch0_input_select}), 32'hfff);
        rd(8'hfc, 16'h0, 1'b1);
        rd(8'h25, 16'h0, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(CH1_CONFIG_IDX, {10'h200, 4'h0, 2'(m)});
            chk(32'(ch1_input_select), 32'(m));
            chk(32'(ch1_phase_delay), 32'h200);
        end
        for (int b = 0; b < 16; b++) begin
            wr(ISOLATED_SUPPLY_CTRL_IDX, {4'h0, 4'(b), 7'h0, 1'(b)});
            chk(32'(supply_freq_band), 32'(b));
            chk(32'(supply_converter_on), 32'(b % 2));
        end
        wr(CH0_OFFSET_TRIM_HIGH_IDX, 16'h0001);
        wr(CH0_OFFSET_TRIM_LOW_IDX, 16'h8000);
        wr(CH0_GAIN_TRIM_HIGH_IDX, 16'h4000);
        wr(CH0_GAIN_TRIM_LOW_IDX, 16'h0000);
        wr(CH1_OFFSET_TRIM_HIGH_IDX, 16'h0000);
        wr(CH1_OFFSET_TRIM_LOW_IDX, 16'h0000);
        smp(24'h001180, 24'h7fffff, 24'h000800, 24'h7fffff, 2'h2);
        smp(24'h000000, 24'h000010, 24'hffff40, 24'h00001f, 2'h0);
        smp(24'h000000, 24'h800000, 24'hffff40, 24'h800000, 2'h2);
        foreach (rat[k]) begin
            wr(CLOCK_DIVIDER_IDX, 16'(k));
            @(posedge mod_clk_tick);
            @(posedge mod_clk_tick);
            n = 0;
            h = 0;
            do begin
                @(posedge pclk);
                #1;
                n++;
                h += mod_clk_level;
            end while (mod_clk_tick !== 1'b1);
            chk(32'(n), 32'(rat[k] * 10));
            chk(32'(h), 32'(rat[k] * 5));
        end
        test_done();
    end
endmodule : test_acr_regs
`default_nettype wire
